// ### src/bia_notice_core.sv
// builds and paces bus interval adjustment notices
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bia_map.svh"

module bia_notice_core
    import bia_pkg::*;
#(
    parameter logic [3:0] SUBTYPE_CODE = 4'h0
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic gen1_speed,
    input wire logic dev_addressed_cfg,
    input wire logic [6:0] dev_addr,
    input wire logic itp_valid,
    input wire logic [6:0] itp_ctrl_addr,
    input wire logic interval_tick,
    input wire logic tp_ready,
    output logic tp_valid,
    output logic [31:0] tp_dw1
);

    // ==========================================
    // helpers
    function automatic logic signed [15:0] clamp_adj(input logic [15:0] raw);
        logic signed [15:0] v;
        v = signed'(raw);
        if (v > `BIA_ADJ_LIMIT) begin
            clamp_adj = `BIA_ADJ_LIMIT;
        end else if (v < -`BIA_ADJ_LIMIT) begin
            clamp_adj = -`BIA_ADJ_LIMIT;
        end else begin
            clamp_adj = v;
        end
    endfunction : clamp_adj

    localparam bia_core_t CORE_RST = '{
        state: BIA_IDLE,
        req: 16'sh0000,
        itp_age: `BIA_ITP_STALE,
        owned: 1'b0,
        gap: `BIA_GAP_RESET,
        clamped: 1'b0,
        dropped: 1'b0,
        tp_valid: 1'b0,
        tp_dw1: 32'h0000_0000,
        rdata: 32'h0000_0000
    };

    bia_core_t st_reg;
    bia_core_t st_next;
    logic gap_start;
    logic gap_done;
    logic itp_fresh;
    logic send_ok;
    logic [31:0] stat_word;

    bia_gap_timer u_gap (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(gap_start),
        .interval_tick(interval_tick),
        .limit(st_reg.gap),
        .done(gap_done)
    );

    assign itp_fresh = st_reg.itp_age < `BIA_ITP_WIN_CYC; // R10
    assign send_ok = gen1_speed && itp_fresh && st_reg.owned && dev_addressed_cfg; // R1 R10

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`BIA_ST_PENDING] = st_reg.state == BIA_WAIT;
        stat_word[`BIA_ST_SENDING] = st_reg.state == BIA_SEND;
        stat_word[`BIA_ST_SPACING] = st_reg.state == BIA_HOLD;
        stat_word[`BIA_ST_CLAMPED] = st_reg.clamped;
        stat_word[`BIA_ST_DROPPED] = st_reg.dropped;
        stat_word[`BIA_ST_FRESH] = itp_fresh;
        stat_word[`BIA_ST_OWNED] = st_reg.owned;
    end

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 32'h0000_0000;
        gap_start = 1'b0;

        // timestamp tracking
        if (itp_valid) begin
            st_next.itp_age = 12'h000;
            st_next.owned = (itp_ctrl_addr == `BIA_ADDR_NONE) || (itp_ctrl_addr == dev_addr); // R10
        end else if (st_reg.itp_age < `BIA_ITP_STALE) begin
            st_next.itp_age = st_reg.itp_age + 12'h001;
        end

        // register reads
        if (reg_rd) begin
            case (reg_addr)
                `BIA_OFS_REQ: st_next.rdata = {16'h0000, st_reg.req};
                `BIA_OFS_STAT: st_next.rdata = stat_word;
                `BIA_OFS_GAP: st_next.rdata = {24'h000000, st_reg.gap};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end

        // sticky clears come first so a set below wins
        if (reg_wr && reg_addr == `BIA_OFS_STAT) begin
            if (reg_wdata[`BIA_ST_CLAMPED]) begin
                st_next.clamped = 1'b0;
            end
            if (reg_wdata[`BIA_ST_DROPPED]) begin
                st_next.dropped = 1'b0;
            end
        end
        if (reg_wr && reg_addr == `BIA_OFS_GAP) begin
            st_next.gap = (reg_wdata[7:0] < `BIA_GAP_MIN) ? `BIA_GAP_MIN : reg_wdata[7:0]; // R8
        end

        // sequencer
        case (st_reg.state)
            BIA_IDLE: begin
                st_next.state = BIA_IDLE;
            end
            BIA_WAIT: begin
                if (send_ok) begin
                    st_next.tp_valid = 1'b1;
                    st_next.tp_dw1 = {st_reg.req, `BIA_RSVD_DW1, `BIA_NTYPE_ADJUST, SUBTYPE_CODE}; // R2 R3 R4
                    st_next.state = BIA_SEND;
                end
            end
            BIA_SEND: begin
                if (tp_ready) begin
                    st_next.tp_valid = 1'b0;
                    gap_start = 1'b1; // R8
                    st_next.state = BIA_HOLD;
                end
            end
            BIA_HOLD: begin
                if (gap_done) begin
                    st_next.state = BIA_IDLE; // R8
                end
            end
            default: begin
                st_next = CORE_RST;
            end
        endcase

        // new request, taken only when idle
        if (reg_wr && reg_addr == `BIA_OFS_REQ) begin
            if (st_reg.state == BIA_IDLE) begin
                st_next.req = clamp_adj(reg_wdata[15:0]); // R9
                if (clamp_adj(reg_wdata[15:0]) != signed'(reg_wdata[15:0])) begin
                    st_next.clamped = 1'b1;
                end
                st_next.state = BIA_WAIT;
            end else begin
                st_next.dropped = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= CORE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign tp_valid = st_reg.tp_valid;
    assign tp_dw1 = st_reg.tp_dw1;

    // ==========================================
    // checks
    logic [7:0] seen_gap;
    logic first_sent;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seen_gap <= 8'h00;
            first_sent <= 1'b0;
        end else if (st_next.tp_valid && !st_reg.tp_valid) begin
            seen_gap <= 8'h00;
            first_sent <= 1'b1;
        end else if (interval_tick && seen_gap != 8'hFF) begin
            seen_gap <= seen_gap + 8'h01;
        end
    end

    a_speed_gate: assert property (@(posedge sys_clk) disable iff (reset) // R1
        $rose(tp_valid) |-> $past(gen1_speed))
        else $error("notice started while not at gen 1 speed");

    a_subtype_field: assert property (@(posedge sys_clk) disable iff (reset) // R2
        tp_valid |-> tp_dw1[`BIA_SUBTYPE_MSB:`BIA_SUBTYPE_LSB] == SUBTYPE_CODE)
        else $error("wrong subtype in notice");

    a_notice_type: assert property (@(posedge sys_clk) disable iff (reset) // R3
        tp_valid |-> tp_dw1[`BIA_NTYPE_MSB:`BIA_NTYPE_LSB] == `BIA_NTYPE_ADJUST)
        else $error("wrong notice type");

    a_adjust_copy: assert property (@(posedge sys_clk) disable iff (reset) // R4
        $rose(tp_valid) |-> tp_dw1[`BIA_ADJ_MSB:`BIA_ADJ_LSB] == $past(st_reg.req)
            && tp_dw1[`BIA_RSVD_MSB:`BIA_RSVD_LSB] == `BIA_RSVD_DW1)
        else $error("adjust value or reserved bits wrong");

    a_request_spacing: assert property (@(posedge sys_clk) disable iff (reset) // R8
        $rose(tp_valid) && $past(first_sent) |-> $past(seen_gap) >= `BIA_GAP_MIN)
        else $error("notices closer than minimum interval gap");

    a_adjust_limit: assert property (@(posedge sys_clk) disable iff (reset) // R9
        tp_valid |-> signed'(tp_dw1[`BIA_ADJ_MSB:`BIA_ADJ_LSB]) <= `BIA_ADJ_LIMIT
            && signed'(tp_dw1[`BIA_ADJ_MSB:`BIA_ADJ_LSB]) >= -`BIA_ADJ_LIMIT)
        else $error("adjust magnitude above limit");

    a_itp_gate: assert property (@(posedge sys_clk) disable iff (reset) // R10
        $rose(tp_valid) |-> $past(itp_fresh && st_reg.owned && dev_addressed_cfg))
        else $error("notice sent without fresh owned timestamp");

    a_offer_stands: assert property (@(posedge sys_clk) disable iff (reset)
        tp_valid && !tp_ready |=> tp_valid && $stable(tp_dw1))
        else $error("notice withdrawn before accepted");

    c_notice_sent: cover property (@(posedge sys_clk) disable iff (reset)
        tp_valid && tp_ready);
    c_request_clamped: cover property (@(posedge sys_clk) disable iff (reset)
        $rose(st_reg.clamped));
    c_request_dropped: cover property (@(posedge sys_clk) disable iff (reset)
        $rose(st_reg.dropped));
    c_second_notice: cover property (@(posedge sys_clk) disable iff (reset)
        $rose(tp_valid) && $past(first_sent));

endmodule : bia_notice_core

// ### shared/bia_map.svh
// constants of the bus interval adjustment notice source
// Contract
// (R1) send notices only at Gen 1 speed
// (R2) subtype at DW1 bit 0, type at bit 4
// (R3) interval adjustment notice type is 0011b
// (R4) signed 16-bit adjust at DW1 bit 16
// (R5) host drops notices when not Gen 1
// (R6) host adds requests to running total
// (R7) host total range -37268 to 37267
// (R8) requests at least eight intervals apart
// (R9) each request magnitude at most 4096
// (R10) send only after fresh owned timestamp, addressed
// (R11) host starts with owner field zero
// (R12) host loads first requester as owner
// (R13) host drops requests from non-owners
// (R14) host clears owner on owner disconnect
// (R15) host may let software pick owner
// (R16) host applies within two intervals
// (R17) eight bit times per unit per 4096
// (R18) per-interval tick counts differ by one
// (R19) tick spacing varies by one interval
// (R20) spread holds until next valid request
// (R21) host uses fractional tick accumulator
// (R22) host saturates total at range limits
`ifndef BIA_MAP_SVH
`define BIA_MAP_SVH

// ==========================================
// register offsets
`define BIA_OFS_REQ 4'h0
`define BIA_OFS_STAT 4'h4
`define BIA_OFS_GAP 4'h8

// ==========================================
// status bit positions
`define BIA_ST_PENDING 0
`define BIA_ST_SENDING 1
`define BIA_ST_SPACING 2
`define BIA_ST_CLAMPED 3
`define BIA_ST_DROPPED 4
`define BIA_ST_FRESH 5
`define BIA_ST_OWNED 6

// ==========================================
// notice layout, second doubleword
`define BIA_SUBTYPE_LSB 0
`define BIA_SUBTYPE_MSB 3
`define BIA_NTYPE_LSB 4
`define BIA_NTYPE_MSB 7
`define BIA_RSVD_LSB 8
`define BIA_RSVD_MSB 15
`define BIA_ADJ_LSB 16
`define BIA_ADJ_MSB 31
`define BIA_NTYPE_ADJUST 4'h3
`define BIA_RSVD_DW1 8'h00

// ==========================================
// limits and timing
`define BIA_ADJ_LIMIT 16'sh1000
`define BIA_GAP_MIN 8'h08
`define BIA_GAP_RESET 8'h08
`define BIA_ADDR_NONE 7'h00
`define BIA_CLK_NS 40
`define BIA_ITP_WIN_NS 125000
`define BIA_ITP_WIN_CYC 12'(`BIA_ITP_WIN_NS / `BIA_CLK_NS)
`define BIA_ITP_STALE 12'(`BIA_ITP_WIN_NS / `BIA_CLK_NS + 1)

`endif

// ### shared/bia_pkg.sv
// types of the bus interval adjustment notice source
package bia_pkg;

    // ==========================================
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        BIA_IDLE = 4'b0001,
        BIA_WAIT = 4'b0010,
        BIA_SEND = 4'b0100,
        BIA_HOLD = 4'b1000
    } bia_state_t;

    // ==========================================
    // state of the notice core
    typedef struct packed {
        bia_state_t state;
        logic signed [15:0] req;
        logic [11:0] itp_age;
        logic owned;
        logic [7:0] gap;
        logic clamped;
        logic dropped;
        logic tp_valid;
        logic [31:0] tp_dw1;
        logic [31:0] rdata;
    } bia_core_t;

    // ==========================================
    // state of the interval gap timer
    typedef struct packed {
        logic [7:0] count;
        logic done;
    } bia_timer_t;

endpackage : bia_pkg

// ### src/bia_gap_timer.sv
// counts bus intervals since a start pulse
`timescale 1ns/1ps
`include "bia_map.svh"

module bia_gap_timer
    import bia_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic interval_tick,
    input wire logic [7:0] limit,
    output logic done
);

    bia_timer_t st_reg;
    bia_timer_t st_next;

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;
        if (start) begin
            st_next.count = 8'h00;
        end else if (interval_tick && st_reg.count != 8'hFF) begin
            st_next.count = st_reg.count + 8'h01;
        end
        st_next.done = !start && (st_next.count >= limit); // R8
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '{count: 8'hFF, done: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;

endmodule : bia_gap_timer

// ### test/bia_host_model.sv
// host side model: bus intervals, timestamps, notice intake
`timescale 1ns/1ps

module bia_host_model
    import bia_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic host_gen1,
    input wire logic itp_en,
    input wire logic slow,
    input wire logic [6:0] owner_ovr,
    input wire logic owner_gone,
    input wire logic [6:0] src_addr,
    input wire logic tp_valid,
    input wire logic [31:0] tp_dw1,
    output logic interval_tick,
    output logic itp_valid,
    output logic [6:0] itp_ctrl_addr,
    output logic tp_ready
);
    // ==========================================
    // interval pacing and notice intake
    logic [3:0] div;
    logic [1:0] wait_cnt;
    logic [6:0] owner;
    logic signed [17:0] total;
    logic signed [17:0] sum;
    logic take;
    logic [17:0] mag;
    logic [16:0] step;
    logic [11:0] frac;
    logic [4:0] adj_ticks;
    assign sum = total + {{2{tp_dw1[31]}}, tp_dw1[31:16]};
    // magnitude of the running total spread over 4096-interval windows
    assign mag = total[17] ? 18'(-total) : 18'(total);
    assign step = {5'h00, frac} + mag[16:0];
    assign take = tp_valid && tp_ready && host_gen1 && tp_dw1[7:4] == 4'h3;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div <= 4'h0;
            wait_cnt <= 2'h0;
            owner <= 7'h00;
            total <= 18'sh00000;
            interval_tick <= 1'b0;
            itp_valid <= 1'b0;
            itp_ctrl_addr <= 7'h00;
            tp_ready <= 1'b0;
            frac <= 12'h000;
            adj_ticks <= 5'h00;
        end else begin
            div <= div + 4'h1;
            // per-interval eight-bit-time ticks: floor or ceil of the average
            if (div == 4'hF) begin
                frac <= step[11:0];
                adj_ticks <= step[16:12];
            end
            interval_tick <= div == 4'hF;
            itp_valid <= itp_en && div == 4'h7;
            itp_ctrl_addr <= (owner_ovr != 7'h00) ? owner_ovr : owner;
            wait_cnt <= (tp_valid && !tp_ready) ? wait_cnt + 2'h1 : 2'h0;
            tp_ready <= tp_valid && !tp_ready && (!slow || wait_cnt == 2'h3);
            if (owner_gone) begin
                owner <= 7'h00;
            end else if (take && (owner == 7'h00 || owner == src_addr)) begin
                owner <= src_addr;
                total <= (sum > 18'sh09193) ? 18'sh09193 :
                         (sum < -18'sh09194) ? -18'sh09194 : sum;
            end
        end
    end
endmodule : bia_host_model

// ### test/bia_notice_core_test.sv
// self-checking bench of the notice core
`timescale 1ns/1ps

module bia_notice_core_test
    import bia_pkg::*;
;
    localparam logic [3:0] SUB = 4'hA;
    logic sys_clk, reset, reg_wr, reg_rd, gen1_speed, cfg, itp_en, slow, gone;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, tp_dw1, rv;
    logic [6:0] dev_addr, owner_ovr, itp_ctrl_addr;
    logic itp_valid, interval_tick, tp_ready, tp_valid, seen_acc;
    int err_total, checks, ticks;
    logic [15:0] row_in [5] = '{16'h0005, 16'hFFFB, 16'h1000, 16'h7FFF, 16'h8000};
    logic [15:0] row_adj [5] = '{16'h0005, 16'hFFFB, 16'h1000, 16'h1000, 16'hF000};
    logic row_clamp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    bia_notice_core #(.SUBTYPE_CODE(SUB)) bia_notice_core_i (.sys_clk(sys_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .gen1_speed(gen1_speed), .dev_addressed_cfg(cfg),
        .dev_addr(dev_addr), .itp_valid(itp_valid), .itp_ctrl_addr(itp_ctrl_addr),
        .interval_tick(interval_tick), .tp_ready(tp_ready), .tp_valid(tp_valid),
        .tp_dw1(tp_dw1));
    bia_host_model bia_host_model_i (.sys_clk(sys_clk), .reset(reset), .host_gen1(gen1_speed),
        .itp_en(itp_en), .slow(slow), .owner_ovr(owner_ovr), .owner_gone(gone),
        .src_addr(dev_addr), .tp_valid(tp_valid), .tp_dw1(tp_dw1),
        .interval_tick(interval_tick), .itp_valid(itp_valid),
        .itp_ctrl_addr(itp_ctrl_addr), .tp_ready(tp_ready));

    // ==========================================
    // shared tasks
    task print_verdict;
        $display("err_total=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    task wait_tp(input logic exp);
        for (int n = 0; n < 60 && tp_valid !== 1'b1; n++) @(posedge sys_clk) #1;
        chk(32'(tp_valid), 32'(exp));
    endtask : wait_tp
    task wait_idle;
        rd(4'h4);
        for (int n = 0; n < 150 && rv[2:0] !== 3'h0; n++) rd(4'h4);
        chk(32'(rv[2:0]), 32'h0);
    endtask : wait_idle

    // ==========================================
    // clock, watchdog, notice spacing monitor
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #(40 * 30000);
        err_total++;
        print_verdict();
    end
    always @(posedge sys_clk) begin
        if (reset) begin
            ticks = 0;
            seen_acc = 1'b0;
        end else if (tp_valid === 1'b1 && tp_ready === 1'b1) begin
            if (seen_acc) chk(32'(ticks >= 8), 32'h1);
            ticks = 0;
            seen_acc = 1'b1;
        end else if (interval_tick === 1'b1) ticks = ticks + 1;
    end

    // ==========================================
    // main sequence
    initial begin
        {reset, reg_wr, reg_rd, gen1_speed, cfg, itp_en, slow, gone} = 8'h9C;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        dev_addr = 7'h12;
        owner_ovr = 7'h00;
        err_total = 0;
        checks = 0;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (20) @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            slow <= i[0];
            wr(4'h0, {16'h0000, row_in[i]});
            wait_tp(1'b1);
            chk(tp_dw1, {row_adj[i], 8'h00, 4'h3, SUB});
            wr(4'h0, 32'h0000_0001);
            rd(4'h4);
            chk(32'(rv[4]), 32'h1);
            chk(32'(rv[3]), 32'(row_clamp[i]));
            wr(4'h4, 32'h0000_0018);
            rd(4'h0);
            chk(32'(rv[15:0]), 32'(row_adj[i]));
            wait_idle();
        end
        gen1_speed <= 1'b0;
        wr(4'h0, 32'h0000_0002);
        wait_tp(1'b0);
        rd(4'h4);
        chk(32'(rv[0]), 32'h1);
        gen1_speed <= 1'b1;
        wait_tp(1'b1);
        wait_idle();
        owner_ovr <= 7'h55;
        repeat (20) @(posedge sys_clk);
        wr(4'h0, 32'h0000_0003);
        wait_tp(1'b0);
        rd(4'h4);
        chk(32'(rv[6]), 32'h0);
        gone <= 1'b1;
        owner_ovr <= 7'h00;
        @(posedge sys_clk);
        gone <= 1'b0;
        wait_tp(1'b1);
        wait_idle();
        cfg <= 1'b0;
        wr(4'h0, 32'h0000_0004);
        wait_tp(1'b0);
        cfg <= 1'b1;
        wait_tp(1'b1);
        wait_idle();
        itp_en <= 1'b0;
        repeat (3200) @(posedge sys_clk);
        wr(4'h0, 32'h0000_0006);
        wait_tp(1'b0);
        rd(4'h4);
        chk(32'(rv[5]), 32'h0);
        itp_en <= 1'b1;
        wait_tp(1'b1);
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        #1 chk({31'h0, tp_valid}, 32'h0);
        chk(tp_dw1, 32'h0);
        rd(4'h8);
        chk(rv, 32'h0000_0008);
        wr(4'h8, 32'h0000_0003);
        rd(4'h8);
        chk(rv, 32'h0000_0008);
        rd(4'hC);
        chk(rv, 32'h0);
        print_verdict();
    end
endmodule : bia_notice_core_test
